//--- fsmc_pkg.sv
package fsmc_pkg;

    localparam int CLK_MHZ = 100;
    // Filter times in microseconds
    localparam int T_BOOST_OC_US = 110000;
    localparam int T_SLOW_US = 100;
    localparam int T_CORE_UV_US = 5;
    localparam int T_FAST_US = 10;
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CYC_BOOST_OC = CNT_W'(T_BOOST_OC_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] CYC_SLOW = CNT_W'(T_SLOW_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] CYC_CORE_UV = CNT_W'(T_CORE_UV_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] CYC_FAST = CNT_W'(T_FAST_US * CLK_MHZ);
    // Duty reduction, percent per degree, in hundredths
    localparam logic [15:0] DUTY_STEP_CENTI = 16'h00e1;
    localparam logic [1:0] TEMP_LIMIT_SEL_RESET = 2'h0;
    localparam logic [3:0] NTC_REDUCE_SEL_RESET = 4'h0;
    localparam logic [3:0] NTC_SHUTOFF_SEL_RESET = 4'hf;

    // Fault index order, same as the struct bit order
    localparam int NF = 11;
    localparam int F_BOOST_OC = 10;
    localparam int F_BOOST_OV = 9;
    localparam int F_IN_OV = 8;
    localparam int F_IN_UV = 7;
    localparam int F_LINE_OC = 6;
    localparam int F_CORE_UV = 5;
    localparam int F_TSD = 4;
    localparam int F_PUMP = 3;
    localparam int F_NTC_SHUT = 2;
    localparam int F_NTC_RED = 1;
    localparam int F_NTC_MISS = 0;

    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_LOAD,
        ST_SOFT_START,
        ST_BOOST_START,
        ST_NORMAL,
        ST_RECOVERY
    } fsmc_state_t;

    typedef struct packed {
        logic boost_overcurrent;
        logic boost_overvoltage;
        logic input_overvoltage;
        logic input_undervoltage;
        logic line_switch_overcurrent;
        logic core_supply_low;
        logic thermal_shutdown;
        logic pump_voltage;
        logic ntc_shutoff;
        logic ntc_reduce;
        logic ntc_missing;
    } fsmc_faults_t;

    typedef struct packed {
        logic line_switch_on;
        logic boost_enable;
        logic sinks_enable;
        logic reg_access_ok;
        logic ntc_current_reduce;
        logic [15:0] duty_reduce_centi;
        logic hybrid_current_reduce;
    } fsmc_ctrl_t;

endpackage

//--- fsmc_fault_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module fsmc_fault_supervisor (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic IO_SUPPLY_ENABLE,
    input wire fsmc_pkg::fsmc_faults_t RAW_FAULTS,
    input wire logic [7:0] DIE_TEMP_OVER,
    input wire logic HYBRID_DIMMING,
    input wire logic NTC_COMP_ENABLE,
    input wire logic [1:0] INTERNAL_TEMP_LIMIT_SEL,
    input wire logic [3:0] NTC_REDUCE_THRESHOLD_SEL,
    input wire logic [3:0] NTC_SHUTOFF_THRESHOLD_SEL,
    input wire logic FAULT_FLAG_CLEAR,
    input wire logic SPI_SELECT_N,
    input wire logic LOAD_DONE,
    input wire logic SOFT_START_DONE,
    input wire logic BOOST_START_DONE,
    output fsmc_pkg::fsmc_faults_t FAULT_FLAGS,
    output fsmc_pkg::fsmc_ctrl_t CTRL,
    output fsmc_pkg::fsmc_state_t MODE,
    output logic [1:0] TEMP_LIMIT_SEL_OUT,
    output logic [3:0] NTC_REDUCE_SEL_OUT,
    output logic [3:0] NTC_SHUTOFF_SEL_OUT,
    output logic FAULT_OUT,
    output logic FAULT_OE_N
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [fsmc_pkg::NF-1:0] raw_s1_reg;
    logic [fsmc_pkg::NF-1:0] raw_s2_reg;
    logic [1:0] en_sync_reg;
    logic [1:0] nss_sync_reg;
    logic nss_last_reg;
    logic [7:0] temp_s1_reg;
    logic [7:0] temp_s2_reg;

    always_ff @(posedge CORE_CLK)
    begin
        raw_s1_reg <= RAW_FAULTS;
        raw_s2_reg <= raw_s1_reg;
        en_sync_reg <= {en_sync_reg[0], IO_SUPPLY_ENABLE};
        nss_sync_reg <= {nss_sync_reg[0], SPI_SELECT_N};
        nss_last_reg <= nss_sync_reg[1];
        temp_s1_reg <= DIE_TEMP_OVER;
        temp_s2_reg <= temp_s1_reg;
    end

    logic enabled;
    logic nss_toggle;
    logic clear_req;
    assign enabled = en_sync_reg[1];
    assign nss_toggle = nss_sync_reg[1] & ~nss_last_reg;
    assign clear_req = FAULT_FLAG_CLEAR | nss_toggle;

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencer

    fsmc_pkg::fsmc_state_t state_reg;
    logic any_recovery_fault;

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N || !enabled)
        begin
            state_reg <= fsmc_pkg::ST_STANDBY;
        end
        else
        begin
            case (state_reg)
                fsmc_pkg::ST_STANDBY: state_reg <= fsmc_pkg::ST_LOAD;
                fsmc_pkg::ST_LOAD:
                    if (LOAD_DONE)
                        state_reg <= fsmc_pkg::ST_SOFT_START;
                fsmc_pkg::ST_SOFT_START:
                    if (any_recovery_fault)
                        state_reg <= fsmc_pkg::ST_RECOVERY;
                    else if (SOFT_START_DONE)
                        state_reg <= fsmc_pkg::ST_BOOST_START;
                fsmc_pkg::ST_BOOST_START:
                    if (any_recovery_fault)
                        state_reg <= fsmc_pkg::ST_RECOVERY;
                    else if (BOOST_START_DONE)
                        state_reg <= fsmc_pkg::ST_NORMAL;
                fsmc_pkg::ST_NORMAL:
                    if (any_recovery_fault)
                        state_reg <= fsmc_pkg::ST_RECOVERY;
                fsmc_pkg::ST_RECOVERY: state_reg <= fsmc_pkg::ST_RECOVERY;
                default: state_reg <= fsmc_pkg::ST_STANDBY;
            endcase
        end
    end

    logic from_soft;
    logic from_boost;
    logic in_normal;
    assign from_soft = state_reg == fsmc_pkg::ST_SOFT_START || state_reg == fsmc_pkg::ST_BOOST_START
        || state_reg == fsmc_pkg::ST_NORMAL;
    assign from_boost = state_reg == fsmc_pkg::ST_BOOST_START || state_reg == fsmc_pkg::ST_NORMAL;
    assign in_normal = state_reg == fsmc_pkg::ST_NORMAL;

    ////////////////////////////////////////////////////////////////////////
    // Monitoring windows and filter times

    logic [fsmc_pkg::NF-1:0] win;
    logic [fsmc_pkg::NF*fsmc_pkg::CNT_W-1:0] limits;

    always_comb
    begin
        win = '0;
        win[fsmc_pkg::F_BOOST_OC] = from_boost;
        win[fsmc_pkg::F_PUMP] = from_boost;
        win[fsmc_pkg::F_IN_OV] = from_soft;
        win[fsmc_pkg::F_IN_UV] = from_soft;
        win[fsmc_pkg::F_LINE_OC] = from_soft;
        win[fsmc_pkg::F_TSD] = from_soft;
        win[fsmc_pkg::F_BOOST_OV] = in_normal;
        win[fsmc_pkg::F_CORE_UV] = enabled;
        win[fsmc_pkg::F_NTC_SHUT] = in_normal & NTC_COMP_ENABLE;
        win[fsmc_pkg::F_NTC_RED] = in_normal & NTC_COMP_ENABLE;
        win[fsmc_pkg::F_NTC_MISS] = in_normal & NTC_COMP_ENABLE;
    end

    always_comb
    begin
        limits = '0;
        limits[fsmc_pkg::F_BOOST_OC*fsmc_pkg::CNT_W +: fsmc_pkg::CNT_W] = fsmc_pkg::CYC_BOOST_OC;
        limits[fsmc_pkg::F_BOOST_OV*fsmc_pkg::CNT_W +: fsmc_pkg::CNT_W] = fsmc_pkg::CYC_SLOW;
        limits[fsmc_pkg::F_IN_OV*fsmc_pkg::CNT_W +: fsmc_pkg::CNT_W] = fsmc_pkg::CYC_SLOW;
        limits[fsmc_pkg::F_IN_UV*fsmc_pkg::CNT_W +: fsmc_pkg::CNT_W] = fsmc_pkg::CYC_SLOW;
        limits[fsmc_pkg::F_LINE_OC*fsmc_pkg::CNT_W +: fsmc_pkg::CNT_W] = fsmc_pkg::CYC_SLOW;
        limits[fsmc_pkg::F_CORE_UV*fsmc_pkg::CNT_W +: fsmc_pkg::CNT_W] = fsmc_pkg::CYC_CORE_UV;
        limits[fsmc_pkg::F_TSD*fsmc_pkg::CNT_W +: fsmc_pkg::CNT_W] = fsmc_pkg::CYC_SLOW;
        limits[fsmc_pkg::F_NTC_MISS*fsmc_pkg::CNT_W +: fsmc_pkg::CNT_W] = fsmc_pkg::CYC_SLOW;
        limits[fsmc_pkg::F_PUMP*fsmc_pkg::CNT_W +: fsmc_pkg::CNT_W] = fsmc_pkg::CYC_FAST;
        limits[fsmc_pkg::F_NTC_SHUT*fsmc_pkg::CNT_W +: fsmc_pkg::CNT_W] = fsmc_pkg::CYC_FAST;
        limits[fsmc_pkg::F_NTC_RED*fsmc_pkg::CNT_W +: fsmc_pkg::CNT_W] = fsmc_pkg::CYC_FAST;
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-fault filter and sticky flag

    logic [fsmc_pkg::NF-1:0] flag_reg;
    logic [fsmc_pkg::NF-1:0] flag_nxt;
    logic [fsmc_pkg::NF-1:0] live;

    genvar gi;
    generate
        for (gi = 0; gi < fsmc_pkg::NF; gi++)
        begin : g_flt
            logic [fsmc_pkg::CNT_W-1:0] cnt_reg;
            logic hit;
            logic ntc_bit;
            assign ntc_bit = gi == fsmc_pkg::F_NTC_SHUT || gi == fsmc_pkg::F_NTC_RED;
            assign hit = cnt_reg == limits[gi*fsmc_pkg::CNT_W +: fsmc_pkg::CNT_W];
            assign live[gi] = raw_s2_reg[gi] & win[gi];
            assign flag_nxt[gi] = (live[gi] && hit) ? 1'b1
                : (clear_req && !(ntc_bit && raw_s2_reg[gi])) ? 1'b0
                : flag_reg[gi];

            always_ff @(posedge CORE_CLK)
            begin
                if (!RST_N || !enabled || !live[gi])
                    cnt_reg <= '0;
                else if (!hit)
                    cnt_reg <= cnt_reg + fsmc_pkg::CNT_W'(1);
            end

            always_ff @(posedge CORE_CLK)
            begin
                if (!RST_N || !enabled)
                    flag_reg[gi] <= 1'b0;
                else
                    flag_reg[gi] <= flag_nxt[gi];
            end
        end
    endgenerate

    assign any_recovery_fault = flag_reg[fsmc_pkg::F_TSD] | flag_reg[fsmc_pkg::F_PUMP]
        | flag_reg[fsmc_pkg::F_BOOST_OC] | flag_reg[fsmc_pkg::F_IN_OV] | flag_reg[fsmc_pkg::F_IN_UV]
        | flag_reg[fsmc_pkg::F_LINE_OC] | flag_reg[fsmc_pkg::F_CORE_UV];

    ////////////////////////////////////////////////////////////////////////
    // Fault pin follows the next value of the pin-driving flags

    logic pin_reg;
    logic pin_src;
    assign pin_src = |(flag_nxt & ~(fsmc_pkg::NF'(1) << fsmc_pkg::F_NTC_MISS));

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N || !enabled)
            pin_reg <= 1'b0;
        else
            pin_reg <= pin_src;
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration capture and thermal reduction

    logic [1:0] tsel_reg;
    logic [3:0] rsel_reg;
    logic [3:0] ssel_reg;
    logic [15:0] duty_reg;
    logic acc_ok;
    assign acc_ok = state_reg == fsmc_pkg::ST_BOOST_START || state_reg == fsmc_pkg::ST_NORMAL
        || state_reg == fsmc_pkg::ST_RECOVERY;

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N || !enabled)
        begin
            tsel_reg <= fsmc_pkg::TEMP_LIMIT_SEL_RESET;
            rsel_reg <= fsmc_pkg::NTC_REDUCE_SEL_RESET;
            ssel_reg <= fsmc_pkg::NTC_SHUTOFF_SEL_RESET;
        end
        else if (acc_ok)
        begin
            tsel_reg <= INTERNAL_TEMP_LIMIT_SEL;
            rsel_reg <= NTC_REDUCE_THRESHOLD_SEL;
            ssel_reg <= NTC_SHUTOFF_THRESHOLD_SEL;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N || !enabled)
            duty_reg <= '0;
        else
            duty_reg <= 16'(temp_s2_reg * fsmc_pkg::DUTY_STEP_CENTI);
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    logic running;
    logic ntc_off;
    assign running = from_soft;
    assign ntc_off = flag_reg[fsmc_pkg::F_NTC_SHUT];

    always_comb
    begin
        CTRL.line_switch_on = running;
        CTRL.boost_enable = from_boost;
        CTRL.sinks_enable = in_normal & ~ntc_off;
        CTRL.reg_access_ok = acc_ok;
        CTRL.ntc_current_reduce = flag_reg[fsmc_pkg::F_NTC_RED];
        CTRL.duty_reduce_centi = duty_reg;
        CTRL.hybrid_current_reduce = HYBRID_DIMMING & (duty_reg != '0);
    end

    assign FAULT_FLAGS = flag_reg;
    assign MODE = state_reg;
    assign TEMP_LIMIT_SEL_OUT = tsel_reg;
    assign NTC_REDUCE_SEL_OUT = rsel_reg;
    assign NTC_SHUTOFF_SEL_OUT = ssel_reg;
    assign FAULT_OUT = 1'b0;
    assign FAULT_OE_N = ~pin_reg;

endmodule
`default_nettype wire

//--- fsmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsmc_host_model (
    input wire logic clk,
    input wire logic fault_out,
    input wire logic fault_oe_n,
    output logic flag_clear,
    output logic spi_select_n,
    output logic fault_pin
);
    // Pulled-up open-drain pin
    assign fault_pin = fault_oe_n ? 1'b1 : fault_out;
    initial
    begin
        flag_clear = 1'b0;
        spi_select_n = 1'b1;
    end
    // Only called once the bus is open
    task automatic write_clear();
        @(negedge clk) flag_clear = 1'b1;
        @(negedge clk) flag_clear = 1'b0;
    endtask
    task automatic toggle_select();
        @(negedge clk) spi_select_n = 1'b0;
        repeat (4) @(negedge clk);
        spi_select_n = 1'b1;
    endtask
endmodule
`default_nettype wire

//--- fsmc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fsmc_sva (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic IO_SUPPLY_ENABLE,
    input wire fsmc_pkg::fsmc_faults_t RAW_FAULTS,
    input wire logic NTC_COMP_ENABLE,
    input wire fsmc_pkg::fsmc_faults_t FAULT_FLAGS,
    input wire fsmc_pkg::fsmc_ctrl_t CTRL,
    input wire fsmc_pkg::fsmc_state_t MODE,
    input wire logic FAULT_OE_N
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_soft_entry;
        $changed(MODE) && MODE == fsmc_pkg::ST_SOFT_START;
    endsequence
    sequence s_reduce_held;
        (RAW_FAULTS.ntc_reduce && IO_SUPPLY_ENABLE && NTC_COMP_ENABLE) [*4] ##0 FAULT_FLAGS.ntc_reduce;
    endsequence
    property p_order;
        s_soft_entry |-> $past(MODE) == fsmc_pkg::ST_LOAD;
    endproperty
    property p_standby;
        !IO_SUPPLY_ENABLE [*4] |=> MODE == fsmc_pkg::ST_STANDBY;
    endproperty
    property p_gate;
        !NTC_COMP_ENABLE [*3] ##0 !FAULT_FLAGS.ntc_reduce |=> !FAULT_FLAGS.ntc_reduce;
    endproperty
    property p_pin_set;
        $rose(FAULT_FLAGS.ntc_reduce) |-> !FAULT_OE_N;
    endproperty
    property p_pin_cause;
        $fell(FAULT_OE_N) |-> FAULT_FLAGS[10:1] != 10'h000;
    endproperty
    property p_sticky;
        s_reduce_held |=> FAULT_FLAGS.ntc_reduce;
    endproperty
    property p_tsd;
        $rose(FAULT_FLAGS.thermal_shutdown) |=> MODE == fsmc_pkg::ST_RECOVERY;
    endproperty
    property p_rec_off;
        MODE == fsmc_pkg::ST_RECOVERY |-> !(CTRL.line_switch_on || CTRL.boost_enable || CTRL.sinks_enable);
    endproperty
    property p_rec_bus;
        MODE == fsmc_pkg::ST_RECOVERY |-> CTRL.reg_access_ok;
    endproperty
    property p_early;
        MODE inside {fsmc_pkg::ST_STANDBY, fsmc_pkg::ST_LOAD, fsmc_pkg::ST_SOFT_START} |-> !CTRL.reg_access_ok;
    endproperty
    property p_shutoff;
        FAULT_FLAGS.ntc_shutoff |-> !CTRL.sinks_enable;
    endproperty
    a_order: assert property (p_order) else $error("soft start not entered from load");
    a_standby: assert property (p_standby) else $error("not standby with enable low");
    a_gate: assert property (p_gate) else $error("reduce flag set while disabled");
    a_pin_set: assert property (p_pin_set) else $error("pin not pulled by reduce flag");
    a_pin_cause: assert property (p_pin_cause) else $error("pin pulled without cause");
    a_sticky: assert property (p_sticky) else $error("reduce flag cleared while raw high");
    a_tsd: assert property (p_tsd) else $error("no recovery after shutdown flag");
    a_rec_off: assert property (p_rec_off) else $error("power path on in recovery");
    a_rec_bus: assert property (p_rec_bus) else $error("bus closed in recovery");
    a_early: assert property (p_early) else $error("bus open before soft start end");
    a_shutoff: assert property (p_shutoff) else $error("sinks on with shutoff flag");
endmodule
bind fsmc_fault_supervisor fsmc_sva i_sva (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .IO_SUPPLY_ENABLE(IO_SUPPLY_ENABLE),
    .RAW_FAULTS(RAW_FAULTS), .NTC_COMP_ENABLE(NTC_COMP_ENABLE), .FAULT_FLAGS(FAULT_FLAGS), .CTRL(CTRL),
    .MODE(MODE), .FAULT_OE_N(FAULT_OE_N));
`default_nettype wire

//--- fsmc_fault_supervisor_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fsmc_fault_supervisor_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b0;
    fsmc_pkg::fsmc_faults_t raw = '0;
    logic [7:0] temp = 8'h00;
    logic hyb = 1'b0;
    logic ntc_en = 1'b0;
    logic ld = 1'b0;
    logic ssd = 1'b0;
    logic bsd = 1'b0;
    fsmc_pkg::fsmc_faults_t flags;
    fsmc_pkg::fsmc_ctrl_t ctrl;
    fsmc_pkg::fsmc_state_t mode;
    logic fout, foe_n, fclr, nss, pin;
    logic [1:0] tsel_o;
    logic [3:0] rsel_o, ssel_o;
    int miscompares = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    fsmc_fault_supervisor i_dut (.CORE_CLK(clk), .RST_N(rst_n), .IO_SUPPLY_ENABLE(en), .RAW_FAULTS(raw),
        .DIE_TEMP_OVER(temp), .HYBRID_DIMMING(hyb), .NTC_COMP_ENABLE(ntc_en), .INTERNAL_TEMP_LIMIT_SEL(2'h1),
        .NTC_REDUCE_THRESHOLD_SEL(4'h3), .NTC_SHUTOFF_THRESHOLD_SEL(4'hc), .FAULT_FLAG_CLEAR(fclr),
        .SPI_SELECT_N(nss), .LOAD_DONE(ld), .SOFT_START_DONE(ssd), .BOOST_START_DONE(bsd), .FAULT_FLAGS(flags),
        .CTRL(ctrl), .MODE(mode), .TEMP_LIMIT_SEL_OUT(tsel_o), .NTC_REDUCE_SEL_OUT(rsel_o),
        .NTC_SHUTOFF_SEL_OUT(ssel_o),
        .FAULT_OUT(fout), .FAULT_OE_N(foe_n));
    fsmc_host_model i_host (.clk(clk), .fault_out(fout), .fault_oe_n(foe_n), .flag_clear(fclr),
        .spi_select_n(nss), .fault_pin(pin));
    task automatic chk(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_start();
        en = 1'b1;
        cyc(6);
        chk("mode_load", 1'b1, mode == fsmc_pkg::ST_LOAD);
        chk("sel_reset", 1'b1, {tsel_o, rsel_o, ssel_o} === {fsmc_pkg::TEMP_LIMIT_SEL_RESET, fsmc_pkg::NTC_REDUCE_SEL_RESET, fsmc_pkg::NTC_SHUTOFF_SEL_RESET});
        ld = 1'b1;
        cyc(3);
        chk("line_switch", 1'b1, ctrl.line_switch_on);
        chk("access_early", 1'b0, ctrl.reg_access_ok);
        ssd = 1'b1;
        bsd = 1'b1;
        cyc(4);
        chk("mode_normal", 1'b1, mode == fsmc_pkg::ST_NORMAL);
        chk("access_ok", 1'b1, ctrl.reg_access_ok);
        chk("sel_taken", 1'b1, {tsel_o, rsel_o, ssel_o} === {2'h1, 4'h3, 4'hc});
        $display("t_start done");
    endtask
    task automatic t_duty();
        temp = 8'h04;
        cyc(6);
        chk("duty", 1'b1, ctrl.duty_reduce_centi === 16'h0384);
        chk("hyb_off", 1'b0, ctrl.hybrid_current_reduce);
        hyb = 1'b1;
        cyc(6);
        chk("hyb_on", 1'b1, ctrl.hybrid_current_reduce);
        temp = 8'h00;
        hyb = 1'b0;
        $display("t_duty done");
    endtask
    task automatic t_ntc();
        raw.ntc_reduce = 1'b1;
        cyc(1100);
        chk("red_gated", 1'b0, flags.ntc_reduce);
        raw.ntc_reduce = 1'b0;
        ntc_en = 1'b1;
        cyc(4);
        raw.ntc_reduce = 1'b1;
        cyc(990);
        chk("red_early", 1'b0, flags.ntc_reduce);
        cyc(20);
        chk("red_set", 1'b1, flags.ntc_reduce);
        chk("red_cur", 1'b1, ctrl.ntc_current_reduce);
        chk("red_pin", 1'b0, pin);
        i_host.write_clear();
        cyc(2);
        chk("red_held", 1'b1, flags.ntc_reduce);
        raw.ntc_reduce = 1'b0;
        cyc(4);
        i_host.write_clear();
        cyc(3);
        chk("red_clr", 1'b0, flags.ntc_reduce);
        chk("pin_free", 1'b1, pin);
        $display("t_ntc done");
    endtask
    task automatic t_miss();
        raw.ntc_missing = 1'b1;
        cyc(9990);
        chk("miss_early", 1'b0, flags.ntc_missing);
        cyc(20);
        chk("miss_set", 1'b1, flags.ntc_missing);
        chk("miss_pin", 1'b1, pin);
        raw.ntc_missing = 1'b0;
        i_host.toggle_select();
        cyc(3);
        chk("miss_clr", 1'b0, flags.ntc_missing);
        $display("t_miss done");
    endtask
    task automatic t_filt();
        raw.ntc_shutoff = 1'b1;
        cyc(900);
        raw.ntc_shutoff = 1'b0;
        cyc(5);
        raw.ntc_shutoff = 1'b1;
        cyc(900);
        chk("filt_restart", 1'b0, flags.ntc_shutoff);
        cyc(110);
        chk("shut_set", 1'b1, flags.ntc_shutoff);
        chk("shut_sinks", 1'b0, ctrl.sinks_enable);
        chk("shut_pin", 1'b0, pin);
        raw.ntc_shutoff = 1'b0;
        cyc(4);
        i_host.write_clear();
        cyc(3);
        chk("shut_clr", 1'b0, flags.ntc_shutoff);
        chk("shut_free", 1'b1, pin);
        $display("t_filt done");
    endtask
    task automatic t_tsd();
        raw.thermal_shutdown = 1'b1;
        cyc(9990);
        chk("tsd_early", 1'b0, flags.thermal_shutdown);
        cyc(25);
        chk("tsd_set", 1'b1, flags.thermal_shutdown);
        chk("tsd_mode", 1'b1, mode == fsmc_pkg::ST_RECOVERY);
        chk("tsd_pin", 1'b0, pin);
        chk("rec_off", 1'b0, ctrl.line_switch_on | ctrl.boost_enable | ctrl.sinks_enable);
        chk("rec_bus", 1'b1, ctrl.reg_access_ok);
        raw.thermal_shutdown = 1'b0;
        en = 1'b0;
        cyc(6);
        chk("standby", 1'b1, mode == fsmc_pkg::ST_STANDBY);
        chk("en_clr", 1'b1, flags === '0);
        chk("en_pin", 1'b1, pin);
        $display("t_tsd done");
    endtask
    task automatic t_core();
        en = 1'b1;
        raw.core_supply_low = 1'b1;
        cyc(500);
        chk("core_early", 1'b0, flags.core_supply_low);
        cyc(15);
        chk("core_set", 1'b1, flags.core_supply_low);
        chk("core_mode", 1'b1, mode == fsmc_pkg::ST_RECOVERY);
        chk("core_off", 1'b0, ctrl.line_switch_on);
        chk("core_pin", 1'b0, pin);
        $display("t_core done");
    endtask
    initial
    begin
        cyc(20);
        rst_n = 1'b1;
        t_start();
        t_duty();
        t_ntc();
        t_miss();
        t_filt();
        t_tsd();
        t_core();
        end_sim();
    end
    initial
    begin
        #450000;
        miscompares++;
        end_sim();
    end
endmodule
`default_nettype wire
